// >>> rtl/dac_ctrl_pkg.sv
package dac_ctrl_pkg;

  // ==========================================================================
  // Command codes
  // ==========================================================================
  localparam logic [3:0] CMD_WRITE_INPUT  = 4'h1;
  localparam logic [3:0] CMD_UPDATE_DAC   = 4'h2;
  localparam logic [3:0] CMD_WRITE_UPDATE = 4'h3;
  localparam logic [3:0] CMD_LOAD_MASK    = 4'h5;
  localparam logic [3:0] CMD_SOFT_RESET   = 4'h6;
  localparam logic [3:0] CMD_REF_SETUP    = 4'h7;

  // ==========================================================================
  // Frame fields
  // ==========================================================================
  localparam int CMD_MSB        = 23;
  localparam int CMD_LSB        = 20;
  localparam int ADDR_MSB       = 19;
  localparam int ADDR_LSB       = 16;
  localparam int DATA_MSB       = 15;
  localparam int DATA_LSB       = 4;
  localparam int ADDR_BIT_A     = 16;
  localparam int ADDR_BIT_B     = 19;
  localparam int MASK_BIT_A     = 0;
  localparam int MASK_BIT_B     = 3;
  localparam int REF_BIT        = 0;

  // ==========================================================================
  // Widths and reset values
  // ==========================================================================
  localparam int NUM_CH         = 2;
  localparam int DAC_W          = 12;
  localparam int MASK_W         = 4;
  localparam logic [MASK_W-1:0] MASK_RESET = 4'h0;
  localparam logic              REF_RESET  = 1'b0;
  localparam logic [DAC_W-1:0]  CODE_ZERO  = 12'h000;
  localparam logic [DAC_W-1:0]  CODE_MID   = 12'h800;

  // Cycles held in the initialising state after power-on or software reset.
  localparam int unsigned INIT_CYCLES = 4;

endpackage : dac_ctrl_pkg

// >>> rtl/dac_code_regs.sv
`timescale 1ns/10ps
// Two-entry code store with registered read data.
module dac_code_regs (
  // Clock and reset
  input  wire logic                               clk,
  input  wire logic                               resetn,
  // Write side
  input  wire logic [dac_ctrl_pkg::NUM_CH-1:0]    wr_en,
  input  wire logic [dac_ctrl_pkg::DAC_W-1:0]     wr_data [dac_ctrl_pkg::NUM_CH],
  // Read side
  output logic      [dac_ctrl_pkg::DAC_W-1:0]     rd_data [dac_ctrl_pkg::NUM_CH]
);

  typedef struct packed {
    logic [dac_ctrl_pkg::NUM_CH-1:0][dac_ctrl_pkg::DAC_W-1:0] mem;
  } state_t;

  state_t s_q;
  state_t s_d;

  always_comb begin
    s_d = s_q;
    for (int i = 0; i < dac_ctrl_pkg::NUM_CH; i++) begin
      if (wr_en[i]) begin
        s_d.mem[i] = wr_data[i];
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  genvar g;
  generate
    for (g = 0; g < dac_ctrl_pkg::NUM_CH; g++) begin : g_rd
      assign rd_data[g] = s_q.mem[g];
    end
  endgenerate

endmodule : dac_code_regs

// >>> rtl/dac_load_ctrl.sv
`timescale 1ns/10ps
// Operation
// [RULE_01] Command 0101 loads four-bit strobe mask
// [RULE_02] Mask command ignores the channel address
// [RULE_03] Mask bits reset to zero
// [RULE_04] Masked channel sees strobe held high
// [RULE_05] Unmasked channel follows strobe pin alone
// [RULE_06] Command 0001 writes input, DAC if low
// [RULE_07] Command 0010 copies input to DAC
// [RULE_08] Command 0011 writes input and DAC
// [RULE_09] Strobe falling edge loads unmasked channels
// [RULE_10] Strobe tied low ignores mask bits
// [RULE_11] Reset pin low clears outputs to code
// [RULE_12] Host holds reset low long enough
// [RULE_13] Outputs stay cleared after reset release
// [RULE_14] No output update while reset low
// [RULE_15] Command 0110 performs software reset
// [RULE_16] Strobe ignored during power-on reset
// [RULE_17] Initialisation waits for reset pin high
// [RULE_18] Select pin picks zero or midscale
// [RULE_19] Outputs hold power-up level until write
// [RULE_20] Command 0111 sets reference bit, default on
// [RULE_21] Strobe low: update on frame completion
// [RULE_22] Strobe high: update on later falling edge
// [RULE_23] Mask and reference default on resets
module dac_load_ctrl (
  // Clock and power-on reset
  input  wire logic                              CLK,
  input  wire logic                              RESETN,
  // Completed 24-bit frame from the serial front end
  input  wire logic                              FRAME_VALID,
  input  wire logic [23:0]                       FRAME_DATA,
  // Device pins
  input  wire logic                              LOAD_STROBE_N,
  input  wire logic                              CLEAR_N,
  input  wire logic                              RESET_LEVEL_SELECT,
  // Converter side
  output logic      [dac_ctrl_pkg::DAC_W-1:0]    DAC_A_CODE,
  output logic      [dac_ctrl_pkg::DAC_W-1:0]    DAC_B_CODE,
  output logic      [dac_ctrl_pkg::DAC_W-1:0]    INPUT_A_CODE,
  output logic      [dac_ctrl_pkg::DAC_W-1:0]    INPUT_B_CODE,
  output logic      [dac_ctrl_pkg::MASK_W-1:0]   LOAD_STROBE_MASK,
  output logic                                   REF_OFF,
  output logic                                   READY
);

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [2:0] {
    ST_HOLD = 3'b001,
    ST_INIT = 3'b010,
    ST_RUN  = 3'b100
  } mode_t;

  typedef struct packed {
    mode_t                                                     mode;
    logic [2:0]                                                init_cnt;
    logic                                                      strobe_prev;
    logic [dac_ctrl_pkg::MASK_W-1:0]                           mask;
    logic                                                      ref_off;
    logic [dac_ctrl_pkg::NUM_CH-1:0][dac_ctrl_pkg::DAC_W-1:0]  dac;
    logic [dac_ctrl_pkg::DAC_W-1:0]                            in_a_q;
    logic [dac_ctrl_pkg::DAC_W-1:0]                            in_b_q;
  } state_t;

  // ==========================================================================
  // Helpers
  // ==========================================================================
  // Address bit test: the per-channel selection of a frame.
  function automatic logic chan_hit(input logic [23:0] f, input int ch);
    if (ch == 0) begin
      chan_hit = f[dac_ctrl_pkg::ADDR_BIT_A];
    end else begin
      chan_hit = f[dac_ctrl_pkg::ADDR_BIT_B];
    end
  endfunction : chan_hit

  // Mask bit of a channel.
  function automatic logic chan_mask(input logic [3:0] m, input int ch);
    if (ch == 0) begin
      chan_mask = m[dac_ctrl_pkg::MASK_BIT_A];
    end else begin
      chan_mask = m[dac_ctrl_pkg::MASK_BIT_B];
    end
  endfunction : chan_mask

  // ==========================================================================
  // Input registers
  // ==========================================================================
  state_t                              s_q;
  state_t                              s_d;
  logic [dac_ctrl_pkg::NUM_CH-1:0]     in_wr;
  logic [dac_ctrl_pkg::DAC_W-1:0]      in_wdata [dac_ctrl_pkg::NUM_CH];
  logic [dac_ctrl_pkg::DAC_W-1:0]      in_rdata [dac_ctrl_pkg::NUM_CH];
  logic [3:0]                          cmd;
  logic [dac_ctrl_pkg::DAC_W-1:0]      new_code;
  logic [dac_ctrl_pkg::DAC_W-1:0]      clear_code;
  logic                                running;
  logic                                soft_rst;

  assign cmd      = FRAME_DATA[dac_ctrl_pkg::CMD_MSB:dac_ctrl_pkg::CMD_LSB];
  assign new_code = FRAME_DATA[dac_ctrl_pkg::DATA_MSB:dac_ctrl_pkg::DATA_LSB];
  // Select pin picks the clear code.
  // [RULE_18] Clear code select
  assign clear_code = RESET_LEVEL_SELECT ? dac_ctrl_pkg::CODE_MID : dac_ctrl_pkg::CODE_ZERO;
  assign running  = (s_q.mode == ST_RUN) && CLEAR_N;
  assign soft_rst = running && FRAME_VALID && (cmd == dac_ctrl_pkg::CMD_SOFT_RESET);

  // Input register writes; soft reset restores the clear code.
  genvar g;
  generate
    for (g = 0; g < dac_ctrl_pkg::NUM_CH; g++) begin : g_in
      // [RULE_06] Input register write
      assign in_wr[g] = (s_q.mode != ST_RUN) || soft_rst || (running && FRAME_VALID
                        && chan_hit(FRAME_DATA, g)
                        && ((cmd == dac_ctrl_pkg::CMD_WRITE_INPUT)
                         || (cmd == dac_ctrl_pkg::CMD_WRITE_UPDATE)));
      assign in_wdata[g] = (running && !soft_rst) ? new_code : clear_code;
    end
  endgenerate

  dac_code_regs u_inputs (
    .clk     (CLK),
    .resetn  (RESETN),
    .wr_en   (in_wr),
    .wr_data (in_wdata),
    .rd_data (in_rdata)
  );

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    logic strobe_fall;
    logic upd;
    strobe_fall = 1'b0;
    upd         = 1'b0;
    s_d             = s_q;
    s_d.strobe_prev = LOAD_STROBE_N;
    s_d.in_a_q      = in_rdata[0];
    s_d.in_b_q      = in_rdata[1];
    strobe_fall     = s_q.strobe_prev && !LOAD_STROBE_N;
    unique case (s_q.mode)
      ST_HOLD: begin
        // [RULE_17] Wait for pin release
        if (CLEAR_N) begin
          s_d.mode     = ST_INIT;
          s_d.init_cnt = '0;
        end
        for (int c = 0; c < dac_ctrl_pkg::NUM_CH; c++) begin
          s_d.dac[c] = clear_code;
        end
      end
      ST_INIT: begin
        // [RULE_16] Strobe ignored while initialising
        // [RULE_19] Outputs at power-up level
        for (int c = 0; c < dac_ctrl_pkg::NUM_CH; c++) begin
          s_d.dac[c] = clear_code;
        end
        if (!CLEAR_N) begin
          s_d.mode = ST_HOLD;
        end else if (s_q.init_cnt == 3'(dac_ctrl_pkg::INIT_CYCLES - 1)) begin
          s_d.mode = ST_RUN;
        end else begin
          s_d.init_cnt = s_q.init_cnt + 3'h1;
        end
      end
      ST_RUN: begin
        if (!CLEAR_N) begin
          // [RULE_11] Clear outputs
          // [RULE_14] Block updates while low
          for (int c = 0; c < dac_ctrl_pkg::NUM_CH; c++) begin
            s_d.dac[c] = clear_code;
          end
        end else if (soft_rst) begin
          // [RULE_15] Software reset
          // [RULE_23] Defaults restored
          s_d.mask    = dac_ctrl_pkg::MASK_RESET;
          s_d.ref_off = dac_ctrl_pkg::REF_RESET;
          s_d.mode    = ST_INIT;
          s_d.init_cnt = '0;
          for (int c = 0; c < dac_ctrl_pkg::NUM_CH; c++) begin
            s_d.dac[c] = clear_code;
          end
        end else begin
          // [RULE_13] Hold until programmed
          if (FRAME_VALID && (cmd == dac_ctrl_pkg::CMD_LOAD_MASK)) begin
            // [RULE_01] Load mask bits
            // [RULE_02] Address ignored
            s_d.mask = FRAME_DATA[dac_ctrl_pkg::MASK_W-1:0];
          end
          if (FRAME_VALID && (cmd == dac_ctrl_pkg::CMD_REF_SETUP)) begin
            // [RULE_20] Reference setup bit
            s_d.ref_off = FRAME_DATA[dac_ctrl_pkg::REF_BIT];
          end
          for (int c = 0; c < dac_ctrl_pkg::NUM_CH; c++) begin
            upd = 1'b0;
            // [RULE_09] Falling edge loads unmasked
            // [RULE_04] Masked channel ignores strobe
            // [RULE_05] Unmasked follows pin
            // [RULE_22] Deferred update
            if (strobe_fall && !chan_mask(s_q.mask, c)) begin
              s_d.dac[c] = in_rdata[c];
              upd        = 1'b1;
            end
            if (FRAME_VALID && chan_hit(FRAME_DATA, c)) begin
              // [RULE_07] Copy input to DAC
              if (cmd == dac_ctrl_pkg::CMD_UPDATE_DAC) begin
                s_d.dac[c] = in_rdata[c];
              end
              // [RULE_08] Write and update
              if (cmd == dac_ctrl_pkg::CMD_WRITE_UPDATE) begin
                s_d.dac[c] = new_code;
              end
              // [RULE_10] Pin low ignores mask
              // [RULE_21] Immediate update
              if ((cmd == dac_ctrl_pkg::CMD_WRITE_INPUT) && !LOAD_STROBE_N) begin
                s_d.dac[c] = new_code;
              end
            end
          end
        end
      end
      default: begin
        s_d.mode = ST_HOLD;
      end
    endcase
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      s_q.mode        <= ST_HOLD;
      s_q.init_cnt    <= '0;
      s_q.strobe_prev <= 1'b1;
      // [RULE_03] Mask default zero
      s_q.mask        <= dac_ctrl_pkg::MASK_RESET;
      s_q.ref_off     <= dac_ctrl_pkg::REF_RESET;
      s_q.dac         <= '0;
      s_q.in_a_q      <= '0;
      s_q.in_b_q      <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign DAC_A_CODE       = s_q.dac[0];
  assign DAC_B_CODE       = s_q.dac[1];
  assign INPUT_A_CODE     = s_q.in_a_q;
  assign INPUT_B_CODE     = s_q.in_b_q;
  assign LOAD_STROBE_MASK = s_q.mask;
  assign REF_OFF          = s_q.ref_off;
  assign READY            = (s_q.mode == ST_RUN);

endmodule : dac_load_ctrl

// >>> dv/dac_load_ctrl_monitor.sv
`timescale 1ns/10ps
module dac_load_ctrl_monitor (
  // Clock and reset
  input wire logic        CLK,
  input wire logic        RESETN,
  // Frame and pins
  input wire logic        FRAME_VALID,
  input wire logic [23:0] FRAME_DATA,
  input wire logic        LOAD_STROBE_N,
  input wire logic        CLEAR_N,
  input wire logic        RESET_LEVEL_SELECT,
  // Converter side
  input wire logic [11:0] DAC_A_CODE,
  input wire logic [11:0] DAC_B_CODE,
  input wire logic [11:0] INPUT_A_CODE,
  input wire logic [11:0] INPUT_B_CODE,
  input wire logic [3:0]  LOAD_STROBE_MASK,
  input wire logic        REF_OFF,
  input wire logic        READY
);
  // ==========================================================================
  // Frame, strobe and clear pin checks
  wire logic        acc = FRAME_VALID && READY && CLEAR_N;
  wire logic        ok  = READY && CLEAR_N && !FRAME_VALID;
  wire logic [3:0]  cmd = FRAME_DATA[23:20];
  wire logic [11:0] clr = RESET_LEVEL_SELECT ? dac_ctrl_pkg::CODE_MID : dac_ctrl_pkg::CODE_ZERO;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);
  chk_mask_load: assert property (acc && cmd == 4'h5 |=>
    LOAD_STROBE_MASK == $past(FRAME_DATA[3:0])) else $error("mask not loaded");
  chk_ref_setup: assert property (acc && cmd == 4'h7 |=>
    REF_OFF == $past(FRAME_DATA[0])) else $error("reference bit wrong");
  chk_clear_code: assert property (!CLEAR_N && READY |=>
    DAC_A_CODE == $past(clr) && DAC_B_CODE == $past(clr)) else $error("clear code wrong");
  chk_soft_reset: assert property (acc && cmd == 4'h6 |=> !READY && !REF_OFF &&
    LOAD_STROBE_MASK == 4'h0 && DAC_A_CODE == $past(clr) ##1 (!READY) [*3])
    else $error("soft reset wrong");
  chk_write_both: assert property (acc && cmd == 4'h3 && FRAME_DATA[19] |=>
    DAC_B_CODE == $past(FRAME_DATA[15:4])) else $error("write and update wrong");
  chk_write_low: assert property (acc && cmd == 4'h1 && !LOAD_STROBE_N && FRAME_DATA[16]
    |=> DAC_A_CODE == $past(FRAME_DATA[15:4])) else $error("direct write wrong");
  chk_write_high: assert property (acc && cmd == 4'h1 && LOAD_STROBE_N |=>
    $stable(DAC_A_CODE) && $stable(DAC_B_CODE)) else $error("deferred write moved output");
  chk_strobe_mask: assert property ($fell(LOAD_STROBE_N) && ok && LOAD_STROBE_MASK[3]
    |=> $stable(DAC_B_CODE) [*2]) else $error("masked channel updated");
  chk_strobe_load: assert property ($fell(LOAD_STROBE_N) && ok && !LOAD_STROBE_MASK[0]
    |-> ##[1:2] DAC_A_CODE == INPUT_A_CODE) else $error("strobe did not load");
  cov_soft: cover property (acc && cmd == 4'h6);
  cov_strobe: cover property ($fell(LOAD_STROBE_N) && ok && LOAD_STROBE_MASK == 4'h0);
  cov_clear: cover property (!CLEAR_N && READY);
endmodule : dac_load_ctrl_monitor

// >>> dv/frame_host.sv
`timescale 1ns/10ps
module frame_host (
  // Clock
  input  wire logic        clk,
  // Request from the bench
  input  wire logic        req,
  input  wire logic [23:0] word,
  // Frame towards the block
  output logic             valid,
  output logic [23:0]      frame
);
  // Idle frame data toggles each cycle so stale words never look valid.
  initial begin
    valid = 1'b0;
    frame = 24'h5a5a5a;
  end
  always @(posedge clk) begin
    valid <= req;
    frame <= req ? word : ~frame;
  end
endmodule : frame_host

// >>> dv/dac_load_ctrl_tb.sv
`timescale 1ns/10ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin error_cnt++; \
  $display("unexpected at %0t: %h vs %h", $time, (a), (b)); end end
module dac_load_ctrl_tb;
  localparam int LIMIT = 5000;
  logic        CLK = 1'b0;
  logic        RESETN = 1'b0;
  logic        LOAD_STROBE_N = 1'b1;
  logic        CLEAR_N = 1'b0;
  logic        RESET_LEVEL_SELECT = 1'b0;
  logic        req = 1'b0;
  logic [23:0] word = 24'h0;
  logic        FRAME_VALID;
  logic [23:0] FRAME_DATA;
  logic [11:0] DAC_A_CODE, DAC_B_CODE, INPUT_A_CODE, INPUT_B_CODE;
  logic [3:0]  LOAD_STROBE_MASK;
  logic        REF_OFF, READY;
  logic [31:0] seed = 32'h0000_4a2f;
  int          error_cnt = 0, compares = 0, cyc = 0;
  int          ia, ib, da, db, mk, rf;
  int          cmds[5] = '{1, 2, 3, 5, 7};
  frame_host frame_host_inst (.clk(CLK), .req, .word, .valid(FRAME_VALID), .frame(FRAME_DATA));
  dac_load_ctrl dac_load_ctrl_inst (.CLK, .RESETN, .FRAME_VALID, .FRAME_DATA, .LOAD_STROBE_N,
    .CLEAR_N, .RESET_LEVEL_SELECT, .DAC_A_CODE, .DAC_B_CODE, .INPUT_A_CODE, .INPUT_B_CODE,
    .LOAD_STROBE_MASK, .REF_OFF, .READY);
  initial begin
    forever #5 CLK = ~CLK;
  end
  always @(posedge CLK) begin
    cyc++;
    if (cyc == LIMIT) begin
      error_cnt++;
      final_report();
    end
  end
  // ==========================================================================
  // Helpers
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  function automatic int clr();
    return RESET_LEVEL_SELECT ? int'(dac_ctrl_pkg::CODE_MID) : int'(dac_ctrl_pkg::CODE_ZERO);
  endfunction : clr
  task automatic tick(int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask : tick
  task automatic reset_model();
    ia = clr();
    ib = ia;
    da = ia;
    db = ia;
    mk = 0;
    rf = 0;
  endtask : reset_model
  task automatic check_all();
    `CHK(DAC_A_CODE, 12'(da))
    `CHK(DAC_B_CODE, 12'(db))
    `CHK(INPUT_A_CODE, 12'(ia))
    `CHK(INPUT_B_CODE, 12'(ib))
    `CHK(LOAD_STROBE_MASK, 4'(mk))
    `CHK(REF_OFF, 1'(rf))
  endtask : check_all
  task automatic por();
    @(posedge CLK);
    RESETN <= 1'b0;
    CLEAR_N <= 1'b0;
    repeat (6) @(posedge CLK);
    RESETN <= 1'b1;
    tick(10);
    `CHK(READY, 1'b0)
    @(posedge CLK);
    CLEAR_N <= 1'b1;
    LOAD_STROBE_N <= 1'b0;
    for (int k = 0; k < 20 && READY !== 1'b1; k++) tick(1);
    `CHK(READY, 1'b1)
    @(posedge CLK);
    LOAD_STROBE_N <= 1'b1;
    tick(1);
    reset_model();
    check_all();
  endtask : por
  task automatic send(int c, logic [31:0] r);
    @(posedge CLK);
    req <= 1'b1;
    word <= {4'(c), r[19:0]};
    @(posedge CLK);
    req <= 1'b0;
    tick(3);
    // refused while the reset pin is low
    if (CLEAR_N) begin
      case (c)
        1, 3: begin
          if (r[16]) ia = r[15:4];
          if (r[19]) ib = r[15:4];
          if (r[16] && (c == 3 || !LOAD_STROBE_N)) da = ia;
          if (r[19] && (c == 3 || !LOAD_STROBE_N)) db = ib;
        end
        2: begin
          if (r[16]) da = ia;
          if (r[19]) db = ib;
        end
        5: mk = r[3:0];
        6: reset_model();
        7: rf = r[0];
      endcase
    end
    if (c == 6) tick(6);
    check_all();
  endtask : send
  task automatic strobe(logic v);
    @(posedge CLK);
    LOAD_STROBE_N <= v;
    tick(3);
    if (!v && CLEAR_N && !mk[0]) da = ia;
    if (!v && CLEAR_N && !mk[3]) db = ib;
    check_all();
  endtask : strobe
  task automatic final_report();
    if (error_cnt == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : final_report
  // ==========================================================================
  // Main sequence
  initial begin
    por();
    for (int i = 0; i < 40; i++) begin
      if (i % 4 == 3)
        strobe(!LOAD_STROBE_N);
      else
        send(cmds[i % 5], rnd());
    end
    @(posedge CLK);
    RESET_LEVEL_SELECT <= 1'b1;
    send(6, rnd());
    send(3, 32'h0009_abc0);
    // pin held low for many cycles
    @(posedge CLK);
    CLEAR_N <= 1'b0;
    da = clr();
    db = da;
    send(3, 32'h0009_1230);
    strobe(1'b0);
    strobe(1'b1);
    @(posedge CLK);
    CLEAR_N <= 1'b1;
    tick(2);
    check_all();
    send(5, 32'h0000_000f);
    send(7, 32'h0000_0001);
    por();
    final_report();
  end
endmodule : dac_load_ctrl_tb
bind dac_load_ctrl dac_load_ctrl_monitor dac_load_ctrl_monitor_inst (.CLK, .RESETN, .FRAME_VALID,
  .FRAME_DATA, .LOAD_STROBE_N, .CLEAR_N, .RESET_LEVEL_SELECT, .DAC_A_CODE, .DAC_B_CODE,
  .INPUT_A_CODE, .INPUT_B_CODE, .LOAD_STROBE_MASK, .REF_OFF, .READY);
